// file: mvc_pkg.sv
// Package: register map, field positions, reset values and states for the
// multiplier VCO calibration register bank.
// Assumes a 16-bit register port with 7-bit addresses.
package mvc_pkg;
    localparam logic [6:0] OFS_VCO_SELECT = 7'h1C;
    localparam logic [6:0] OFS_CAP_START = 7'h1D;
    localparam logic [6:0] OFS_TRIM_A = 7'h21;
    localparam logic [6:0] OFS_TRIM_B = 7'h22;
    localparam logic [6:0] OFS_READBACK = 7'h41;
    localparam logic [6:0] OFS_TRIM_C = 7'h43;
    localparam logic [6:0] OFS_OUT_CTRL = 7'h19;

    localparam logic [15:0] RST_VCO_SELECT = 16'h0A08;
    localparam logic [15:0] RST_CAP_START = 16'h05FF;
    localparam logic [15:0] RST_TRIM_A = 16'h7777;
    localparam logic [15:0] RST_TRIM_B = 16'h0007;
    localparam logic [15:0] RST_READBACK = 16'h65F0;
    localparam logic [15:0] RST_TRIM_C = 16'h50C8;
    localparam logic [15:0] RST_OUT_CTRL = 16'h0211;

    // Writable bit masks; zero bits are read-only
    localparam logic [15:0] WM_VCO_SELECT = 16'h1FFF;
    localparam logic [15:0] WM_CAP_START = 16'h1FFF;
    localparam logic [15:0] WM_TRIM_B = 16'h3FFF;
    localparam logic [15:0] WM_READBACK = 16'hFE0F;
    localparam logic [15:0] WM_FULL = 16'hFFFF;

    localparam int OVERRIDE_BIT = 12;
    localparam int VSEL_LSB = 9;
    localparam int RB_LSB = 4;
    localparam int MUX_LSB = 0;
    localparam int MULT_LSB = 3;
    localparam logic [2:0] FUNC_MULT = 3'h3;
    localparam logic [2:0] MULT_MIN = 3'h1;
    localparam logic [2:0] MULT_MAX = 3'h4;
    localparam logic [2:0] CORE_COUNT = 3'h5;
    localparam logic [4:0] RB_NONE = 5'h1F;

    typedef enum logic [1:0] {
        MVC_IDLE, MVC_SEARCH, MVC_TUNE, MVC_LOCKED
    } mvc_cal_e;
endpackage

// file: mvc_reg_mem.sv
// Small register file holding the six 16-bit words of the bank.
// Assumes index decode by the caller; read data is registered.
`timescale 1ns/1ns
module mvc_reg_mem
    import mvc_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic [2:0] wr_idx, // Write slot
    input wire logic wr_en, // Write strobe
    input wire logic [15:0] wr_data, // Write data
    input wire logic [2:0] rd_idx, // Read slot
    output logic [15:0] rd_data, // Registered read data
    output logic [15:0] slot0, // Select word
    output logic [15:0] slot1, // Cap start word
    output logic [15:0] slot4 // Readback word, writable bits
);
    logic [15:0] mem [0:5];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem[0] <= RST_VCO_SELECT;
            mem[1] <= RST_CAP_START;
            mem[2] <= RST_TRIM_A;
            mem[3] <= RST_TRIM_B;
            mem[4] <= RST_READBACK;
            mem[5] <= RST_TRIM_C;
            rd_data <= 16'h0000;
        end else if (ce) begin
            if (wr_en && wr_idx <= 3'h5) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= (rd_idx <= 3'h5) ? mem[rd_idx] : 16'h0000;
        end
    end

    assign slot0 = mem[0];
    assign slot1 = mem[1];
    assign slot4 = mem[4];
endmodule

// file: mvc_regs.sv
// Top of the multiplier VCO calibration register bank with a simple
// calibration sequencer. Assumes a synchronous 16-bit register port,
// one access per cycle, read data valid two cycles after the read strobe.
`timescale 1ns/1ns
module mvc_regs
    import mvc_pkg::*;
(
    input wire logic ref_clk, // 125 MHz clock
    input wire logic sys_rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic [6:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic core_fit, // Analog: current core can lock
    output logic [15:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid
    output logic mult_active, // Multiplier mode in use
    output logic [2:0] vco_select_sel, // Core driven to PLL
    output logic [7:0] vco_cap_code, // Capacitance code to PLL
    output logic cal_busy, // Calibration running
    output logic cal_locked // Calibration settled
);
    logic [15:0] out_ctrl;
    logic [15:0] mem_rdata;
    logic [15:0] w_sel;
    logic [15:0] w_cap;
    logic [15:0] w_rb;
    logic [4:0] active_vco_readback;
    logic [2:0] core;
    logic [7:0] cap;
    logic [2:0] tries;
    logic rd_mem;
    logic rd_ctrl;
    logic fit_s1, fit_s2, fit_s3;
    logic fit_ok;
    logic rd_any;
    logic mult_prev;
    mvc_cal_e state, next_state;

    function automatic logic [2:0] slot_of(input logic [6:0] a);
        unique case (a)
            OFS_VCO_SELECT: slot_of = 3'h0;
            OFS_CAP_START: slot_of = 3'h1;
            OFS_TRIM_A: slot_of = 3'h2;
            OFS_TRIM_B: slot_of = 3'h3;
            OFS_READBACK: slot_of = 3'h4;
            OFS_TRIM_C: slot_of = 3'h5;
            default: slot_of = 3'h7;
        endcase
    endfunction

    function automatic logic [15:0] wmask_of(input logic [2:0] s);
        unique case (s)
            3'h0: wmask_of = WM_VCO_SELECT;
            3'h1: wmask_of = WM_CAP_START;
            3'h3: wmask_of = WM_TRIM_B;
            3'h4: wmask_of = WM_READBACK;
            default: wmask_of = WM_FULL;
        endcase
    endfunction

    // One-cold encoding of core 1..5
    function automatic logic [4:0] one_cold(input logic [2:0] c);
        one_cold = ~(5'h10 >> (c - 3'h1));
    endfunction

    wire [2:0] wr_slot = slot_of(reg_addr);
    wire mem_wr = ce && reg_wr && wr_slot != 3'h7;
    // Read-only bits are written to storage as zero; reset still loads them from the RST_ values
    wire [15:0] masked_w = reg_wdata & wmask_of(wr_slot);
    wire override = w_sel[OVERRIDE_BIT];
    wire [2:0] vsel = w_sel[VSEL_LSB +: 3];
    wire [2:0] start_core = (vsel >= MULT_MIN && vsel <= CORE_COUNT)
                            ? vsel : CORE_COUNT;
    wire [2:0] mult_factor = out_ctrl[MULT_LSB +: 3];
    wire mode_mult = out_ctrl[MUX_LSB +: 3] == FUNC_MULT
                     && mult_factor >= MULT_MIN
                     && mult_factor <= MULT_MAX;
    wire [2:0] next_core = (core == CORE_COUNT) ? MULT_MIN : core + 3'h1;
    wire [15:0] rb_word = (w_rb & WM_READBACK)
                          | {7'h00, active_vco_readback, 4'h0};

    mvc_reg_mem u_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_idx(wr_slot),
        .wr_en(mem_wr),
        .wr_data(masked_w),
        .rd_idx(wr_slot),
        .rd_data(mem_rdata),
        .slot0(w_sel),
        .slot1(w_cap),
        .slot4(w_rb)
    );

    // Function select lives beside the bank so mode can be chosen
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_ctrl <= RST_OUT_CTRL;
        end else if (ce && reg_wr && reg_addr == OFS_OUT_CTRL) begin
            out_ctrl <= reg_wdata;
        end
    end

    // Read handshake: source picked at the strobe, data valid two cycles later
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_mem <= 1'b0;
            rd_ctrl <= 1'b0;
            rd_any <= 1'b0;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            rd_mem <= reg_rd && wr_slot != 3'h7 && wr_slot != 3'h4;
            rd_ctrl <= reg_rd && reg_addr == OFS_OUT_CTRL;
            rd_any <= reg_rd;
            reg_rvalid <= rd_any;
        end
    end

    wire [15:0] rd_mux = rd_ctrl ? out_ctrl : mem_rdata;
    logic rd_rb;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_rb <= 1'b0;
        end else if (ce) begin
            rd_rb <= reg_rd && reg_addr == OFS_READBACK;
        end
    end
    wire [15:0] rd_sel = rd_rb ? rb_word
                       : (rd_mem || rd_ctrl) ? rd_mux : 16'h0000;
    // Registered so the read port leaves from a flip-flop
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= rd_sel;
        end
    end

    // Three-stage synchroniser; level taken once stages 2 and 3 agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fit_s1 <= 1'b0;
            fit_s2 <= 1'b0;
            fit_s3 <= 1'b0;
            fit_ok <= 1'b0;
        end else if (ce) begin
            fit_s1 <= core_fit;
            fit_s2 <= fit_s1;
            fit_s3 <= fit_s2;
            if (fit_s2 == fit_s3) begin
                fit_ok <= fit_s2;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            MVC_IDLE: begin
                if (mode_mult && !mult_prev) begin
                    next_state = override ? MVC_LOCKED : MVC_SEARCH;
                end
            end
            MVC_SEARCH: begin
                if (fit_ok) begin
                    next_state = MVC_TUNE;
                end else if (tries == CORE_COUNT - 3'h1) begin
                    next_state = MVC_TUNE;
                end
            end
            MVC_TUNE: begin
                if (fit_ok || cap == 8'h00) begin
                    next_state = MVC_LOCKED;
                end
            end
            MVC_LOCKED: begin
                next_state = MVC_LOCKED;
            end
        endcase
        if (!mode_mult) begin
            next_state = MVC_IDLE;
        end
    end

    // Calibration sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= MVC_IDLE;
            mult_prev <= 1'b0;
            core <= CORE_COUNT;
            cap <= RST_CAP_START[7:0];
            tries <= 3'h0;
            active_vco_readback <= RB_NONE;
        end else if (ce) begin
            state <= next_state;
            mult_prev <= mode_mult;
            if (state == MVC_IDLE) begin
                core <= override ? vsel : start_core;
                cap <= w_cap[7:0];
                tries <= 3'h0;
            end else if (state == MVC_SEARCH && !fit_ok) begin
                core <= next_core;
                tries <= tries + 3'h1;
            end else if (state == MVC_TUNE && !fit_ok && cap != 8'h00) begin
                cap <= cap - 8'h01;
            end
            if (override && state == MVC_LOCKED) begin
                core <= vsel;
            end
            if (next_state == MVC_LOCKED) begin
                active_vco_readback <= one_cold(core);
            end else if (!mode_mult) begin
                active_vco_readback <= RB_NONE;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mult_active <= 1'b0;
            vco_select_sel <= CORE_COUNT;
            vco_cap_code <= RST_CAP_START[7:0];
            cal_busy <= 1'b0;
            cal_locked <= 1'b0;
        end else if (ce) begin
            mult_active <= mode_mult;
            vco_select_sel <= core;
            vco_cap_code <= cap;
            cal_busy <= state == MVC_SEARCH || state == MVC_TUNE;
            cal_locked <= state == MVC_LOCKED;
        end
    end
endmodule

// file: mvc_regs_asserts.sv
// Checker: port relations of the VCO calibration register bank.
// Assumes binding to mvc_regs; mirrors the written control fields.
`timescale 1ns/1ns
module mvc_chk
    import mvc_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic ce, // Enable
    input wire logic [6:0] reg_addr, // Offset
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic reg_rvalid, // Read valid
    input wire logic mult_active, // Mode
    input wire logic [2:0] vco_select_sel, // Core
    input wire logic [7:0] vco_cap_code, // Cap code
    input wire logic cal_busy, // Busy
    input wire logic cal_locked // Locked
);
    logic ovr_q, mode_q;
    logic [2:0] vsel_q;
    logic [7:0] cap_q;
    logic [6:0] ra_p, ra_q;
    wire [2:0] fac = reg_wdata[5:3];
    wire go = ce && reg_wr;
    wire mode_ok = reg_wdata[2:0] == FUNC_MULT && fac >= MULT_MIN
        && fac <= MULT_MAX;
    wire [2:0] start = (vsel_q >= 3'h1 && vsel_q <= 3'h5) ? vsel_q : 3'h5;
    wire [4:0] cold = vco_select_sel == 3'h1 ? 5'h0F
        : vco_select_sel == 3'h2 ? 5'h17 : vco_select_sel == 3'h3 ? 5'h1B
        : vco_select_sel == 3'h4 ? 5'h1D : vco_select_sel == 3'h5 ? 5'h1E
        : 5'h1F;
    wire rb_rd = reg_rvalid && ra_q == OFS_READBACK;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ovr_q, vsel_q, cap_q, mode_q, ra_q} <= 20'h5FF00;
            ra_p <= 7'h00;
        end else begin
            // Address follows the two-stage read pipeline
            if (ce) ra_p <= reg_addr;
            if (ce) ra_q <= ra_p;
            if (go && reg_addr == OFS_VCO_SELECT) begin
                {ovr_q, vsel_q} <= reg_wdata[12:9];
            end
            if (go && reg_addr == OFS_CAP_START) cap_q <= reg_wdata[7:0];
            if (go && reg_addr == OFS_OUT_CTRL) mode_q <= mode_ok;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_readback_idle: assert property (
        rb_rd && !mult_active |-> reg_rdata[8:4] == RB_NONE)
        else $error("readback not idle code");
    a_readback_onecold: assert property (
        rb_rd && cal_locked |-> reg_rdata[8:4] == cold)
        else $error("readback not one-cold of core");
    a_ro_upper_zero: assert property (
        reg_rvalid && (ra_q == OFS_VCO_SELECT || ra_q == OFS_CAP_START)
        |-> reg_rdata[15:13] == 3'h0) else $error("upper bits not zero");
    a_ro_trim_zero: assert property (
        reg_rvalid && ra_q == OFS_TRIM_B |-> reg_rdata[15:14] == 2'h0)
        else $error("trim upper bits not zero");
    a_override_core: assert property (
        cal_locked && ovr_q |-> vco_select_sel == vsel_q)
        else $error("forced core not driven");
    a_override_fast: assert property (
        $rose(mult_active) && ovr_q |-> ##[0:3] cal_locked)
        else $error("forced core lock late");
    a_search_start: assert property (
        $rose(cal_busy) && !ovr_q |-> ##[0:1] vco_select_sel == start)
        else $error("search start core wrong");
    a_cap_seed: assert property (
        $rose(cal_busy) |-> ##[0:1] vco_cap_code == cap_q)
        else $error("cap start code wrong");
    a_mode_enter: assert property (
        $rose(mode_q) |-> ##[0:2] mult_active)
        else $error("multiplier mode not entered");
    cover property ($rose(cal_locked) && ovr_q);
    cover property ($rose(cal_locked) && !ovr_q);
    cover property (rb_rd && cal_locked);
    cover property ($rose(cal_locked) && vco_cap_code == 8'h00);
endmodule
bind mvc_regs mvc_chk u_chk(.ref_clk, .sys_rst, .ce, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .mult_active,
    .vco_select_sel, .vco_cap_code, .cal_busy, .cal_locked);

// file: mvc_regs_tb.sv
// Testbench: reset values, field access, mode select, calibration.
// Assumes mvc_regs with its checker bound; inputs move on falling edge.
`timescale 1ns/1ns
module mvc_regs_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic core_fit = 1'b0;
    logic [15:0] reg_rdata;
    logic reg_rvalid, mult_active, cal_busy, cal_locked;
    logic [2:0] vco_select_sel;
    logic [7:0] vco_cap_code;
    int failures = 0;
    int tests_run = 0;
    logic [22:0] rt [7] = '{{7'h1C, 16'h0A08}, {7'h1D, 16'h05FF},
        {7'h21, 16'h7777}, {7'h22, 16'h0007}, {7'h41, 16'h65F0},
        {7'h43, 16'h50C8}, {7'h19, 16'h0211}};
    // Address, write data, expected read
    logic [38:0] wt [11] = '{{7'h1C, 32'hFFFF1FFF}, {7'h1D, 32'hFFFF1FFF},
        {7'h22, 32'hFFFF3FFF}, {7'h41, 32'hFFFFFFFF}, {7'h41, 32'h640065F0},
        {7'h21, 32'h66666666}, {7'h22, 32'h00050005}, {7'h43, 32'h51CB51CB},
        {7'h1C, 32'h0A080A08}, {7'h1D, 32'h05FF05FF}, {7'h20, 32'h12340000}};
    logic [4:0] oc [5] = '{5'h0F, 5'h17, 5'h1B, 5'h1D, 5'h1E};
    mvc_regs dut(.ref_clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .core_fit, .reg_rdata, .reg_rvalid, .mult_active,
        .vco_select_sel, .vco_cap_code, .cal_busy, .cal_locked);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        chk({reg_rvalid, reg_rdata}, {1'b1, e});
    endtask
    task automatic cal(input logic [15:0] sel);
        int n;
        wr(7'h1C, sel);
        wr(7'h19, 16'h001B);
        for (n = 0; n < 100 && cal_locked !== 1'b1; n++) @(negedge ref_clk);
        chk({16'h0, cal_locked}, 17'h1);
    endtask
    initial begin
        int i;
        for (i = 0; i < 5000; i++) @(posedge ref_clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        foreach (rt[i]) rdc(rt[i][22:16], rt[i][15:0]);
        foreach (wt[i]) begin
            wr(wt[i][38:32], wt[i][31:16]);
            rdc(wt[i][38:32], wt[i][15:0]);
        end
        ce = 1'b0;
        wr(7'h21, 16'h1234);
        ce = 1'b1;
        rdc(7'h21, 16'h6666);
        core_fit = 1'b1;
        wr(7'h1D, 16'h0540);
        for (int f = 0; f < 9; f++) begin
            wr(7'h19, f == 8 ? 16'h001A : {10'h0, f[2:0], 3'h3});
            repeat (3) @(negedge ref_clk);
            chk({16'h0, mult_active}, {16'h0, f >= 1 && f <= 4});
            wr(7'h19, 16'h0211);
            repeat (3) @(negedge ref_clk);
        end
        for (int s = 0; s < 2; s++) begin
            cal(s ? 16'h0008 : 16'h0408);
            chk({14'h0, vco_select_sel}, s ? 17'h5 : 17'h2);
            chk({9'h0, vco_cap_code}, 17'h40);
            rdc(7'h41, s ? 16'h65E0 : 16'h6570);
            wr(7'h19, 16'h0211);
            rdc(7'h41, 16'h65F0);
        end
        // No core fits: search returns to start, cap runs down to zero
        core_fit = 1'b0;
        cal(16'h0608);
        chk({14'h0, vco_select_sel}, 17'h3);
        chk({9'h0, vco_cap_code}, 17'h0);
        rdc(7'h41, 16'h65B0);
        wr(7'h19, 16'h0211);
        core_fit = 1'b1;
        for (int c = 1; c < 6; c++) begin
            cal({3'h0, 1'b1, c[2:0], 9'h008});
            chk({14'h0, vco_select_sel}, {14'h0, c[2:0]});
            rdc(7'h41, {7'h32, oc[c - 1], 4'h0});
            wr(7'h19, 16'h0211);
        end
        tally_and_finish;
    end
endmodule
